/* verilog/asrp_pkg.sv */
// Package of timing constants and states for the async SRAM host port
package asrp_pkg;
    // ------------------------------------------------------------------
    // Clock and geometry
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 5000;
    localparam int ADDR_W        = 15;
    localparam int DATA_W        = 8;

    // ------------------------------------------------------------------
    // Times in ps, as printed in ns
    // ------------------------------------------------------------------
    localparam int ADDRESS_ACCESS_DELAY_PS        = 25000;
    localparam int OE_ACCESS_DELAY_PS             = 9000;
    localparam int SELECT_OUTPUT_DISABLE_DELAY_PS = 10000;
    localparam int WRITE_PULSE_WIDTH_PS           = 20000;
    localparam int WRITE_RECOVERY_WIDTH_PS        = 5000;
    localparam int DATA_SETUP_TO_WRITE_END_PS     = 15000;
    localparam int ADDRESS_SETUP_TO_WRITE_END_PS  = 20000;
    localparam int WRITE_CYCLE_TIME_PS            = 25000;
    localparam int READ_CYCLE_TIME_PS             = 25000;
    localparam int STROBE_OUTPUT_REENABLE_PS      = 5000;

    // Least times round up to whole cycles, never below one
    function automatic int cyc_up(input int t_ps);
        int n;
        n = (t_ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (n < 1) ? 1 : n;
    endfunction : cyc_up

    // ------------------------------------------------------------------
    // Cycle counts
    // ------------------------------------------------------------------
    // A read holds the pins for the access, two synchroniser cycles and
    // one margin cycle, so the byte is sampled after the access time and
    // never on its very edge
    localparam int READ_CYC  = cyc_up(ADDRESS_ACCESS_DELAY_PS) + 3;
    localparam int RDREL_CYC = cyc_up(SELECT_OUTPUT_DISABLE_DELAY_PS);
    localparam int WPULSE_CYC = cyc_up(WRITE_PULSE_WIDTH_PS);
    localparam int WREC_CYC   = cyc_up(WRITE_RECOVERY_WIDTH_PS);
    localparam int CNT_W      = 4;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_READ  = 3'b001,
        ST_RREL  = 3'b010,
        ST_WRITE = 3'b011,
        ST_WREC  = 3'b100
    } asrp_state_e;
endpackage : asrp_pkg

/* verilog/asrp_sync.sv */
// Two-flop synchroniser for the data bus returning from the memory
`timescale 1ns/1ps
module asrp_sync (
    // Clock and reset
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst_n,
    // Data
    input  wire logic [7:0] i_async,
    output logic      [7:0] o_sync
);
    logic [7:0] stage1;

    // First stage feeds only the second
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            stage1 <= 8'h00;
            o_sync <= 8'h00;
        end else begin
            stage1 <= i_async;
            o_sync <= stage1;
        end
    end
endmodule : asrp_sync

/* verilog/asrp_host.sv */
// Host controller driving a 32K x 8 asynchronous static RAM
`timescale 1ns/1ps
// Operation
// - Read only with select, OE low, enable high
// - Address read valid after access delay
// - Select-started read needs early address
// - Enable-started read needs early address, select
// - Write needs strobe low, select low, enable high
// - Deassert one control between writes
// - Write pulse at least 20 ns
// - Recovery at least 5 ns
// - Address stable before and during write
// - Data valid 15 ns before write end
// - Address valid 20 ns before write end
// - Address, data held after write end
// - Write cycle at least 25 ns
// - Select, enable active 20 ns before end
// - Read cycles at least 25 ns
module asrp_host (
    // Clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_resetn,
    // User request
    input  wire logic        i_req,
    input  wire logic        i_we,
    input  wire logic [14:0] i_addr,
    input  wire logic [7:0]  i_wdata,
    output logic             o_ready,
    output logic             o_rvalid,
    output logic      [7:0]  o_rdata,
    // Memory pins
    output logic      [14:0] o_mem_addr,
    output logic             o_select_low,
    output logic             o_chip_enable,
    output logic             o_write_strobe_low,
    output logic             o_output_enable_low,
    output logic      [7:0]  o_dq_out,
    output logic             o_dq_oe,
    input  wire logic [7:0]  i_dq_in
);
    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ------------------------------------------------------------------
    // Data bus return path
    // ------------------------------------------------------------------
    logic [7:0] dq_sync;

    asrp_sync u_sync (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (rst_n),
        .i_async   (i_dq_in),
        .o_sync    (dq_sync)
    );

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    asrp_pkg::asrp_state_e state;
    asrp_pkg::asrp_state_e next_state;
    logic [asrp_pkg::CNT_W-1:0] cnt;
    logic [asrp_pkg::CNT_W-1:0] next_cnt;

    localparam logic [3:0] READ_N  = 4'(asrp_pkg::READ_CYC);
    localparam logic [3:0] RREL_N  = 4'(asrp_pkg::RDREL_CYC);
    localparam logic [3:0] WPULSE_N = 4'(asrp_pkg::WPULSE_CYC);
    localparam logic [3:0] WREC_N  = 4'(asrp_pkg::WREC_CYC);

    wire logic cnt_done = (cnt == 4'h1);

    // Next state; each phase counts down its own minimum length
    always_comb begin
        next_state = state;
        next_cnt   = (cnt > 4'h1) ? cnt - 4'h1 : 4'h1;
        case (state)
            asrp_pkg::ST_IDLE: begin
                if (i_req) begin
                    next_state = i_we ? asrp_pkg::ST_WRITE
                                      : asrp_pkg::ST_READ;
                    next_cnt   = i_we ? WPULSE_N : READ_N;
                end
            end
            asrp_pkg::ST_READ: begin
                if (cnt_done) begin
                    next_state = asrp_pkg::ST_RREL;
                    next_cnt   = RREL_N;
                end
            end
            asrp_pkg::ST_RREL: begin
                if (cnt_done) begin
                    next_state = asrp_pkg::ST_IDLE;
                end
            end
            asrp_pkg::ST_WRITE: begin
                if (cnt_done) begin
                    next_state = asrp_pkg::ST_WREC;
                    next_cnt   = WREC_N;
                end
            end
            asrp_pkg::ST_WREC: begin
                if (cnt_done) begin
                    next_state = asrp_pkg::ST_IDLE;
                end
            end
            default: begin
                next_state = asrp_pkg::ST_IDLE;
            end
        endcase
    end

    // State and counter registers
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= asrp_pkg::ST_IDLE;
            cnt   <= 4'h1;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
        end
    end

    wire logic start = (state == asrp_pkg::ST_IDLE) && i_req;

    // Address and write data latched at start, held through idle until the next start
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_mem_addr <= 15'h0000;
            o_dq_out   <= 8'h00;
        end else if (start) begin
            o_mem_addr <= i_addr;
            o_dq_out   <= i_wdata;
        end
    end

    // Controls: select and enable frame every access, strobe the write
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_select_low        <= 1'b1;
            o_chip_enable       <= 1'b0;
            o_write_strobe_low  <= 1'b1;
            o_output_enable_low <= 1'b1;
            o_dq_oe             <= 1'b0;
        end else begin
            // Address, select and enable move on one edge: zero setup
            o_select_low  <= !(next_state == asrp_pkg::ST_READ ||
                               next_state == asrp_pkg::ST_WRITE);
            o_chip_enable <= (next_state == asrp_pkg::ST_READ ||
                              next_state == asrp_pkg::ST_WRITE);
            o_write_strobe_low  <= !(next_state == asrp_pkg::ST_WRITE);
            o_output_enable_low <= !(next_state == asrp_pkg::ST_READ);
            // Drive data only while writing; keep bus free in release
            o_dq_oe <= (next_state == asrp_pkg::ST_WRITE);
        end
    end

    // Capture read data at the end of the access window
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_rvalid <= 1'b0;
            o_rdata  <= 8'h00;
        end else begin
            o_rvalid <= (state == asrp_pkg::ST_READ) && cnt_done;
            if ((state == asrp_pkg::ST_READ) && cnt_done) begin
                o_rdata <= dq_sync;
            end
        end
    end

    // Ready shown in every idle cycle but the first after reset; it drops on the edge that starts an access
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_ready <= 1'b0;
        end else begin
            o_ready <= (next_state == asrp_pkg::ST_IDLE);
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence s_wr_pulse;
        !o_write_strobe_low [*4];
    endsequence

    a_write_pulse_len: assert property (@(posedge i_ref_clk)
        disable iff (!rst_n)
        $fell(o_write_strobe_low) |-> (!o_write_strobe_low)[*4])
        else $error("write pulse shorter than minimum");

    a_write_conds_all: assert property (@(posedge i_ref_clk)
        disable iff (!rst_n)
        !o_write_strobe_low |-> !o_select_low && o_chip_enable)
        else $error("write strobe without select and enable");

    a_recovery_gap: assert property (@(posedge i_ref_clk)
        disable iff (!rst_n)
        $rose(o_write_strobe_low) |=> o_write_strobe_low)
        else $error("recovery gap missing");

    a_addr_stable_wr: assert property (@(posedge i_ref_clk)
        disable iff (!rst_n)
        !o_write_strobe_low |=> o_write_strobe_low
            || $stable(o_mem_addr))
        else $error("address moved during write");

    a_data_held_wr: assert property (@(posedge i_ref_clk)
        disable iff (!rst_n)
        $rose(o_write_strobe_low) |-> $stable(o_dq_out))
        else $error("write data not held at write end");

    a_read_conds_ok: assert property (@(posedge i_ref_clk)
        disable iff (!rst_n)
        !o_output_enable_low |-> o_write_strobe_low && !o_select_low
            && o_chip_enable && !o_dq_oe)
        else $error("read controls inconsistent");

    a_read_wait_len: assert property (@(posedge i_ref_clk)
        disable iff (!rst_n)
        $fell(o_output_enable_low) |-> (!o_output_enable_low)[*8]
            ##1 o_rvalid)
        else $error("read sampled before access time");

    a_write_cycle_len: assert property (@(posedge i_ref_clk)
        disable iff (!rst_n)
        s_wr_pulse ##1 $rose(o_write_strobe_low) |-> !o_ready
            ##1 o_ready)
        else $error("write cycle too short");
endmodule : asrp_host

/* tb/asrp_sram_model.sv */
// Behavioural model of the 32K x 8 asynchronous static RAM
`timescale 1ns/1ps
module asrp_sram_model (
    // Memory controls
    input  wire logic [14:0] i_addr,
    input  wire logic        i_select_low,
    input  wire logic        i_chip_enable,
    input  wire logic        i_write_strobe_low,
    input  wire logic        i_output_enable_low,
    // Data bus
    input  wire logic [7:0]  i_dq,
    output logic      [7:0]  o_dq,
    output logic             o_dq_en
);
    // ----------------------------------------------------------------
    // Array and write path
    // ----------------------------------------------------------------
    logic [7:0]  mem [0:32767];
    logic [7:0]  dq_d;
    logic [14:0] a_d;
    logic        wr_on;
    logic        acc_ok = 1'b0;
    logic        oe_ok  = 1'b0;
    logic        we_ok  = 1'b0;
    real         t_acc  = 0.0;
    real         t_oe   = 0.0;
    real         t_we   = 0.0;
    real         t_adr  = 0.0;
    logic        hold_ok = 1'b0;
    logic [7:0]  q_last = 8'h00;
    // A write is open only while all three controls agree
    assign wr_on = !i_select_low && i_chip_enable
                   && !i_write_strobe_low;
    // Slightly late copies, so a zero hold at the closing edge suffices
    always @(i_dq) dq_d <= #0.1 i_dq;
    always @(i_addr) a_d <= #0.1 i_addr;
    always @(negedge wr_on) mem[a_d] = dq_d;
    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    // Any address, select or enable edge restarts the access
    always @(i_addr, i_select_low, i_chip_enable)
        t_acc = $realtime;
    always @(negedge i_output_enable_low) t_oe = $realtime;
    always @(posedge i_write_strobe_low) t_we = $realtime;
    always @(i_addr) t_adr = $realtime;
    // Polling is coarse but avoids cancelling scheduled events
    always #0.25 begin
        acc_ok = ($realtime - t_acc) >= 25.0;
        oe_ok  = ($realtime - t_oe) >= 9.0;
        we_ok  = ($realtime - t_we) >= 5.0;
        hold_ok = ($realtime - t_adr) < 3.0;
        if (acc_ok && oe_ok) q_last = mem[i_addr];
    end
    // Drivers follow the controls at once: release is never late
    assign o_dq_en = !i_select_low && i_chip_enable && i_write_strobe_low
                     && !i_output_enable_low && we_ok;
    // Last good byte lingers briefly after an address move, then a
    // pattern shows until the new access completes
    assign o_dq = hold_ok ? q_last
                : (acc_ok && oe_ok) ? mem[i_addr] : ~i_addr[7:0];
endmodule : asrp_sram_model

/* tb/async_sram_read_write_port_tb.sv */
// Self-checking testbench of the async SRAM host port
`timescale 1ns/1ps
module async_sram_read_write_port_tb;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic        i_ref_clk = 1'b0;
    logic        i_resetn, i_req, i_we, o_ready, o_rvalid, m_en, o_dq_oe;
    logic        o_select_low, o_chip_enable, o_write_strobe_low;
    logic        o_output_enable_low;
    logic        wseen = 1'b0;
    logic [14:0] i_addr, o_mem_addr;
    logic [7:0]  i_wdata, o_rdata, o_dq_out, i_dq_in, m_dq, q;
    logic [7:0]  float_dq = 8'h5a;
    logic [22:0] wq;
    logic [14:0] at [4] = '{15'h0000, 15'h7fff, 15'h1234, 15'h4aa5};
    int          num_errors = 0, checks = 0, lat, wl = 0, sl = 0;
    // Answer seen at the falling edge after the finishing rising edge
    localparam int WR_LAT = asrp_pkg::WPULSE_CYC + asrp_pkg::WREC_CYC + 1;
    localparam int RD_LAT = asrp_pkg::READ_CYC + 1;

    always #2.5 i_ref_clk = ~i_ref_clk;
    // Wire level: host, then memory, else a value flipping every cycle
    assign i_dq_in = o_dq_oe ? o_dq_out : m_en ? m_dq : float_dq;
    always @(posedge i_ref_clk) float_dq <= ~i_dq_in;

    asrp_host DUT (.i_ref_clk, .i_resetn, .i_req, .i_we, .i_addr, .i_wdata,
        .o_ready, .o_rvalid, .o_rdata, .o_mem_addr, .o_select_low,
        .o_chip_enable, .o_write_strobe_low, .o_output_enable_low,
        .o_dq_out, .o_dq_oe, .i_dq_in);
    asrp_sram_model MEM (.i_addr(o_mem_addr), .i_select_low(o_select_low),
        .i_chip_enable(o_chip_enable), .i_dq(i_dq_in), .o_dq(m_dq),
        .i_write_strobe_low(o_write_strobe_low), .o_dq_en(m_en),
        .i_output_enable_low(o_output_enable_low));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic cmp(input logic [22:0] got, input logic [22:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp

    // Waits for ready, then holds the request for exactly one edge
    task automatic put_req(input logic w, input logic [14:0] a,
                           input logic [7:0] d);
        lat = 0;
        do begin @(negedge i_ref_clk); lat++; end
        while (o_ready !== 1'b1 && lat < 50);
        cmp(23'(o_ready), 23'h1);
        @(posedge i_ref_clk);
        i_req <= 1'b1;
        i_we <= w;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_ref_clk);
        i_req <= 1'b0;
    endtask : put_req

    // One request; waits for its answer and checks the latency
    task automatic xfer(input logic w, input logic [14:0] a,
                        input logic [7:0] d);
        put_req(w, a, d);
        lat = 0;
        do begin @(negedge i_ref_clk); lat++; end
        while ((w ? o_ready : o_rvalid) !== 1'b1 && lat < 50);
        q = o_rdata;
        cmp(23'(lat), w ? 23'(WR_LAT) : 23'(RD_LAT));
    endtask : xfer

    task automatic chk_idle;
        @(negedge i_ref_clk);
        cmp({o_select_low, o_chip_enable, o_write_strobe_low,
             o_output_enable_low, o_dq_oe, o_ready, o_rvalid},
            23'h58);
    endtask : chk_idle

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    // Array ends and inside, then each address read back in its own select-framed access
    task automatic t_write_read;
        for (int i = 0; i < 4; i++)
            xfer(1'b1, at[i], 8'h3c ^ at[i][7:0]);
        for (int i = 0; i < 4; i++) begin
            xfer(1'b0, at[i], 8'h00);
            cmp(q, 8'h3c ^ at[i][7:0]);
        end
    endtask : t_write_read

    // Requests held while busy must leave no trace in the array
    task automatic t_refused;
        xfer(1'b1, 15'h0100, 8'ha5);
        @(posedge i_ref_clk);
        i_req <= 1'b1;
        i_addr <= 15'h0200;
        i_wdata <= 8'h11;
        @(posedge i_ref_clk);
        i_addr <= 15'h0100;
        i_wdata <= 8'hee;
        repeat (3) @(posedge i_ref_clk);
        i_req <= 1'b0;
        xfer(1'b0, 15'h0100, 8'h00);
        cmp(q, 8'ha5);
        xfer(1'b0, 15'h0200, 8'h00);
        cmp(q, 8'h11);
    endtask : t_refused

    // Reset in mid write idles every pin, then the port works again
    task automatic t_mid_reset;
        put_req(1'b1, 15'h0300, 8'h77);
        @(posedge i_ref_clk);
        i_resetn <= 1'b0;
        chk_idle();
        repeat (3) @(posedge i_ref_clk);
        i_resetn <= 1'b1;
        xfer(1'b1, 15'h0300, 8'h5c);
        xfer(1'b0, 15'h0300, 8'h00);
        cmp(q, 8'h5c);
    endtask : t_mid_reset

    // Pin watcher: write pulse shape and select framing every cycle
    always @(negedge i_ref_clk) begin
        if (!i_resetn) begin
            wl = 0;
            sl = 0;
            wseen = 1'b0;
        end else begin
            if (o_output_enable_low === 1'b0)
                cmp({o_select_low, o_chip_enable, o_write_strobe_low,
                     o_dq_oe}, 23'h6);
            if (o_write_strobe_low === 1'b0) begin
                cmp({o_select_low, o_chip_enable, o_dq_oe}, 23'h3);
                if (wl == 0) wq = {o_mem_addr, o_dq_out};
                cmp({o_mem_addr, o_dq_out}, wq);
                wl++;
                wseen = 1'b1;
            end else if (wl != 0) begin
                cmp(23'(wl >= 4), 23'd1);
                wl = 0;
            end
            if (o_select_low === 1'b0) sl++;
            else if (sl != 0) begin
                cmp(23'(sl >= (wseen ? 4 : 5)), 23'd1);
                sl = 0;
                wseen = 1'b0;
            end
        end
    end

    task automatic summarize;
        if (num_errors == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : summarize

    initial begin
        i_resetn = 1'b0;
        i_req = 1'b0;
        i_we = 1'b1;
        i_addr = 15'h0000;
        i_wdata = 8'h00;
        repeat (2) @(posedge i_ref_clk);
        chk_idle();
        @(posedge i_ref_clk);
        i_resetn <= 1'b1;
        t_write_read();
        t_refused();
        t_mid_reset();
        summarize();
    end

    // Watchdog: the whole run needs a few microseconds at most
    initial begin
        #20000;
        num_errors++;
        summarize();
    end
endmodule : async_sram_read_write_port_tb
